// ---- ssr_flag_bit.sv ----
`timescale 1ns/1ps
// one sticky flag: set wins over clear
module ssr_flag_bit
  import ssr_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      flag_o <= RESET_VAL;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end
endmodule : ssr_flag_bit

// ---- ssr_pkg.sv ----
package ssr_pkg;
  // status byte bit positions
  localparam int unsigned STB_ESB_BIT = 5;
  localparam int unsigned STB_MAV_BIT = 4;
  localparam int unsigned STB_RQS_BIT = 6;
  // standard event bit positions
  localparam int unsigned EV_PON_BIT  = 7;
  localparam int unsigned EV_URQ_BIT  = 6;
  localparam int unsigned EV_CME_BIT  = 5;
  localparam int unsigned EV_EXE_BIT  = 4;
  localparam int unsigned EV_DDE_BIT  = 3;
  localparam int unsigned EV_QYE_BIT  = 2;
  localparam int unsigned EV_RQC_BIT  = 1;
  localparam int unsigned EV_OPC_BIT  = 0;
  // masks and reset values
  localparam logic [7:0] SRE_WRITE_MASK = 8'hBF;
  localparam logic [7:0] EV_LIVE_MASK   = 8'hBD;
  localparam logic [7:0] SRE_RESET      = 8'h00;
  localparam logic [7:0] ESE_RESET      = 8'h00;
  localparam logic [7:0] EV_RESET       = 8'h80;
  localparam logic [7:0] DDS_RESET      = 8'h00;
endpackage : ssr_pkg

// ---- ssr_queue_model.sv ----
`timescale 1ns/1ps
module ssr_queue_model
(
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic push_i,
  input  wire logic pop_i,
  output logic      not_empty_o,
  output logic      empty_read_o
);
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      not_empty_o <= 1'b0;
    else if (pop_i)
      not_empty_o <= 1'b0;
    else if (push_i)
      not_empty_o <= 1'b1;
  end
  // reading an empty queue is reported as a query error
  assign empty_read_o = pop_i && !not_empty_o;
endmodule : ssr_queue_model

// ---- ssr_status_request.sv ----
`timescale 1ns/1ps
module ssr_status_request
  import ssr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clear_status_i,
  input  wire logic       sre_write_i,
  input  wire logic [7:0] sre_wdata_i,
  input  wire logic       ese_write_i,
  input  wire logic [7:0] ese_wdata_i,
  input  wire logic       event_read_i,
  input  wire logic       serial_poll_i,
  input  wire logic       queue_not_empty_i,
  input  wire logic [3:0] dev_summary_i,
  input  wire logic       cmd_error_i,
  input  wire logic       exec_error_i,
  input  wire logic       dev_error_i,
  input  wire logic       query_error_i,
  input  wire logic       op_complete_i,
  output logic [7:0]      sre_rdata_o,
  output logic [7:0]      ese_rdata_o,
  output logic [7:0]      event_rdata_o,
  output logic [7:0]      status_byte_o,
  output logic [7:0]      poll_byte_o,
  output logic            srq_o
);
  logic [7:0] service_request_mask;
  logic [7:0] event_enable_mask;
  logic [7:0] event_set;
  logic [7:0] standard_event_flags;
  logic [7:0] next_stb;
  logic       next_mss;
  logic       mss_q;
  logic       rqs;
  logic       ev_clr;
  logic [3:0] dev_sum;

  // enable masks are touched only by their own writes, never by clear-status
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      service_request_mask <= SRE_RESET;
    else if (sre_write_i)
      service_request_mask <= sre_wdata_i & SRE_WRITE_MASK;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      event_enable_mask <= ESE_RESET;
    else if (ese_write_i)
      event_enable_mask <= ese_wdata_i;
  end

  always_comb
  begin
    event_set             = 8'h00;
    event_set[EV_CME_BIT] = cmd_error_i;
    event_set[EV_EXE_BIT] = exec_error_i;
    event_set[EV_DDE_BIT] = dev_error_i;
    event_set[EV_QYE_BIT] = query_error_i;
    event_set[EV_OPC_BIT] = op_complete_i;
    event_set[EV_URQ_BIT] = 1'b0;
    event_set[EV_RQC_BIT] = 1'b0;
  end

  assign ev_clr = clear_status_i | event_read_i;

  // bits 6 and 1 are left unbuilt so they read as constant zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_ev
      if (EV_LIVE_MASK[gi])
      begin : g_live
        ssr_flag_bit #(
          .RESET_VAL (EV_RESET[gi])
        ) u_flag (
          .sys_clk_i (sys_clk_i),
          .sys_rst_i (sys_rst_i),
          .set_i     (event_set[gi]),
          .clr_i     (ev_clr),
          .flag_o    (standard_event_flags[gi])
        );
      end
      else
      begin : g_zero
        assign standard_event_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // device summary bits from extended registers are cleared by clear-status
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      dev_sum <= DDS_RESET[3:0];
    else if (clear_status_i)
      dev_sum <= 4'h0;
    else
      dev_sum <= dev_summary_i;
  end

  always_comb
  begin
    next_stb              = 8'h00;
    next_stb[3:0]         = dev_sum;
    next_stb[STB_MAV_BIT] = queue_not_empty_i;
    next_stb[STB_ESB_BIT] = |(standard_event_flags & event_enable_mask);
    next_stb[STB_RQS_BIT] = 1'b0;
    next_mss              = |(next_stb & service_request_mask & SRE_WRITE_MASK);
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mss_q <= 1'b0;
    else
      mss_q <= next_mss;
  end

  // request latches on a new cause and drops after a poll
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rqs <= 1'b0;
    else if (next_mss && !mss_q)
      rqs <= 1'b1;
    else if (serial_poll_i || !next_mss)
      rqs <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      status_byte_o <= 8'h00;
      poll_byte_o   <= 8'h00;
      srq_o         <= 1'b0;
    end
    else
    begin
      status_byte_o <= next_stb | ({7'h00, next_mss} << STB_RQS_BIT);
      poll_byte_o   <= next_stb | ({7'h00, rqs} << STB_RQS_BIT);
      srq_o         <= rqs;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sre_rdata_o   <= 8'h00;
      ese_rdata_o   <= 8'h00;
      event_rdata_o <= 8'h00;
    end
    else
    begin
      sre_rdata_o   <= service_request_mask & SRE_WRITE_MASK;
      ese_rdata_o   <= event_enable_mask;
      event_rdata_o <= standard_event_flags;
    end
  end
endmodule : ssr_status_request

// ---- ssr_status_request_properties.sv ----
`timescale 1ns/1ps
module ssr_status_request_properties
(
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       clear_status_i,
  input wire logic       sre_write_i,
  input wire logic [7:0] sre_wdata_i,
  input wire logic       event_read_i,
  input wire logic       serial_poll_i,
  input wire logic       queue_not_empty_i,
  input wire logic       cmd_error_i,
  input wire logic [7:0] sre_rdata_o,
  input wire logic [7:0] event_rdata_o,
  input wire logic [7:0] status_byte_o,
  input wire logic       srq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_mask_bit6_zero: assert property (sre_rdata_o[6] == 1'b0) else $error("mask bit 6 set");
  a_mask_load: assert property ($past(sre_write_i, 2) |-> sre_rdata_o == ($past(sre_wdata_i, 2) & 8'hBF))
    else $error("mask load wrong");
  a_mask_hold: assert property (!sre_write_i ##1 !sre_write_i |-> ##1 $stable(sre_rdata_o)) else $error("mask moved");
  a_clear_keeps_mask: assert property (clear_status_i && !sre_write_i |-> ##2 $stable(sre_rdata_o))
    else $error("clear changed mask");
  a_unused_events: assert property (event_rdata_o[6] == 1'b0 && event_rdata_o[1] == 1'b0)
    else $error("unused event set");
  a_cmd_latch: assert property (cmd_error_i ##1 !(event_read_i || clear_status_i) |-> ##1 event_rdata_o[5])
    else $error("command error lost");
  a_mav_follow: assert property (status_byte_o[4] == $past(queue_not_empty_i)) else $error("mav wrong");
  a_poll_drops: assert property (serial_poll_i |-> ##2 !srq_o) else $error("request kept");
endmodule : ssr_status_request_properties

bind ssr_status_request ssr_status_request_properties ssr_status_request_properties_i (.sys_clk_i, .sys_rst_i,
  .clear_status_i, .sre_write_i, .sre_wdata_i, .event_read_i, .serial_poll_i, .queue_not_empty_i,
  .cmd_error_i, .sre_rdata_o, .event_rdata_o, .status_byte_o, .srq_o);

// ---- ssr_status_request_test.sv ----
`timescale 1ns/1ps
module ssr_status_request_test;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [10:0] st = 11'h000;
  logic [7:0]  wd = 8'h00;
  logic        q_ne, q_err, srq;
  logic [7:0]  sre_r, ese_r, ev_r, stb, pb;
  logic [3:0]  dv = 4'h0;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  initial forever #25 sys_clk_i = ~sys_clk_i;
  ssr_queue_model ssr_queue_model_i (.sys_clk_i, .sys_rst_i, .push_i(st[1]), .pop_i(st[0]),
    .not_empty_o(q_ne), .empty_read_o(q_err));
  ssr_status_request ssr_status_request_i (.sys_clk_i, .sys_rst_i, .clear_status_i(st[10]),
    .sre_write_i(st[9]), .sre_wdata_i(wd), .ese_write_i(st[8]), .ese_wdata_i(wd), .event_read_i(st[7]),
    .serial_poll_i(st[6]), .queue_not_empty_i(q_ne), .dev_summary_i(dv), .cmd_error_i(st[5]),
    .exec_error_i(st[4]), .dev_error_i(st[3]), .query_error_i(q_err), .op_complete_i(st[2]),
    .sre_rdata_o(sre_r), .ese_rdata_o(ese_r), .event_rdata_o(ev_r), .status_byte_o(stb),
    .poll_byte_o(pb), .srq_o(srq));
  // strobe vector: clear, mask, enable, read, poll, cmd, exec, dev, opc, push, pop
  task go(input logic [10:0] s, input logic [7:0] d);
    @(negedge sys_clk_i);
    st = s;
    wd = d;
    @(negedge sys_clk_i);
    st = 11'h000;
    repeat (3) @(negedge sys_clk_i);
  endtask : go
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(ev_r, 8'h80);
    go(11'h200, 8'hFF);
    chk(sre_r, 8'hBF);
    go(11'h100, 8'h3D);
    chk(ese_r, 8'h3D);
    chk(stb, 8'h00);
    go(11'h03C, 8'h00);
    chk(ev_r, 8'hB9);
    chk(stb, 8'h60);
    chk(pb, 8'h60);
    chk({7'h0, srq}, 8'h01);
    go(11'h040, 8'h00);
    chk({7'h0, srq}, 8'h00);
    chk(pb, 8'h20);
    go(11'h001, 8'h00);
    chk(ev_r, 8'hBD);
    go(11'h080, 8'h00);
    chk(stb, 8'h00);
    go(11'h002, 8'h00);
    chk(stb, 8'h50);
    chk({7'h0, srq}, 8'h01);
    go(11'h024, 8'h00);
    go(11'h400, 8'h00);
    chk(ev_r, 8'h00);
    chk(stb, 8'h50);
    chk(ese_r, 8'h3D);
    chk(sre_r, 8'hBF);
    go(11'h001, 8'h00);
    chk(ev_r, 8'h00);
    chk(stb, 8'h00);
    dv = 4'h8;
    go(11'h000, 8'h00);
    chk(stb, 8'h48);
    chk(pb, 8'h48);
    chk({7'h0, srq}, 8'h01);
    go(11'h040, 8'h00);
    chk(pb, 8'h08);
    chk(stb, 8'h48);
    chk({7'h0, srq}, 8'h00);
    dv = 4'h0;
    go(11'h200, 8'h40);
    chk(sre_r, 8'h00);
    give_verdict();
  end
endmodule : ssr_status_request_test
